// [rtl/lbd_consts.vh]
`ifndef LBD_CONSTS_VH
`define LBD_CONSTS_VH

// register offsets
`define LBD_REG_CMD      8'h00
`define LBD_REG_FLAGS    8'h04
`define LBD_REG_PC       8'h08
`define LBD_REG_OPERAND  8'h0c
`define LBD_REG_STATUS   8'h10
`define LBD_REG_DECODE   8'h14
`define LBD_REG_SAVED_PC 8'h18

// flag bit positions in the flags register
`define LBD_FLAG_C 0
`define LBD_FLAG_V 1
`define LBD_FLAG_Z 2
`define LBD_FLAG_N 3

// status bit positions
`define LBD_ST_BUSY  0
`define LBD_ST_DONE  1
`define LBD_ST_TAKEN 2
`define LBD_ST_ILL   3

// reset values
`define LBD_PC_RST    32'h0000_0000
`define LBD_FLAGS_RST 4'h0

// instruction groups
`define LBD_GRP_NONE  3'h0
`define LBD_GRP_LOGIC 3'h1
`define LBD_GRP_BRA   3'h2
`define LBD_GRP_JUMP  3'h3
`define LBD_GRP_COND  3'h4
`define LBD_GRP_CALL  3'h5
`define LBD_GRP_RET   3'h6

// logical operation codes
`define LBD_LOP_AND 3'h0
`define LBD_LOP_XOR 3'h1
`define LBD_LOP_OR  3'h2
`define LBD_LOP_SHL 3'h3
`define LBD_LOP_SHR 3'h4
`define LBD_LOP_ROT 3'h5

// operand sizes
`define LBD_SZ_BYTE 2'h0
`define LBD_SZ_HALF 2'h1
`define LBD_SZ_WORD 2'h2

// branch condition codes
`define LBD_CND_CC 3'h0
`define LBD_CND_CS 3'h1
`define LBD_CND_VC 3'h2
`define LBD_CND_VS 3'h3
`define LBD_CND_EQ 3'h4
`define LBD_CND_NE 3'h5
`define LBD_CND_LT 3'h6

// completion times in processor cycles
`define LBD_CYC_NOT_TAKEN  4'd5
`define LBD_CYC_TAKEN      4'd7
`define LBD_CYC_BRANCH     4'd5
`define LBD_CYC_JUMP       4'd7
`define LBD_CYC_CALL       4'd7
`define LBD_CYC_RETURN     4'd13
`define LBD_CYC_LOGIC      4'd1

`endif

// [rtl/lbd_decoder.v]
`timescale 1ns/1ps
//
// Functional notes
// - and: byte/half/word two-operand BB/BA/B8, three-address FB/FA/F8.
// - exclusive or: B7/B6/B4 two-operand, F7/F6/F4 three-address.
// - inclusive or: B3/B2/B0 two-operand, F3/F2/F0 three-address.
// - logical left shift byte D3, half D2, word D0, three operands.
// - word logical right shift D4 and word rotate D8, word size only.
// - unconditional branch, jump or return loads pc with the target.
// - conditional transfer tests flags; pc takes the target when condition holds, else advances by the byte length.
// - subroutine entry saves return address; return restores it.
// - branch 7B two bytes, 7A three bytes, jump 24 with operand.
// - 53 and 52 branch when carry clear.
// - 5B and 5A branch when carry set.
// - shared carry encodings run one identical operation.
// - 63 and 62 branch when overflow clear.
// - 6B and 6A branch when overflow set.
// - equal: 7F/6F short, 7E/6E long, duplicates identical.
// - not equal: 77/67 short, 76/66 long, duplicates identical.
// - 4B and 4A branch when signed less than.
// - short conditional: 5-10 cycles not taken, 7-14 taken.
// - long conditional: 5-10 cycles not taken, 7-12 taken.
`include "lbd_consts.vh"

module lbd_decoder (
    input  wire        clk,
    input  wire        rstn,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output wire [31:0] rdata,
    output wire        busy,
    output wire [31:0] pc
);

// ----------------------------------------------------------------
// decode function
// ----------------------------------------------------------------
// result: [12] known, [11:9] group, [8:6] op or condition,
//         [5:4] size, [3] three-address, [2] long displacement,
//         [1:0] byte length of fixed-length transfers
function [12:0] lbd_decode;
    input [7:0] op;
    begin
        lbd_decode = 13'h0000;
        case (op)
            8'hbb: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_AND, `LBD_SZ_BYTE, 4'h0};
            8'hba: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_AND, `LBD_SZ_HALF, 4'h0};
            8'hb8: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_AND, `LBD_SZ_WORD, 4'h0};
            8'hfb: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_AND, `LBD_SZ_BYTE, 4'h8};
            8'hfa: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_AND, `LBD_SZ_HALF, 4'h8};
            8'hf8: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_AND, `LBD_SZ_WORD, 4'h8};
            8'hb7: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_XOR, `LBD_SZ_BYTE, 4'h0};
            8'hb6: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_XOR, `LBD_SZ_HALF, 4'h0};
            8'hb4: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_XOR, `LBD_SZ_WORD, 4'h0};
            8'hf7: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_XOR, `LBD_SZ_BYTE, 4'h8};
            8'hf6: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_XOR, `LBD_SZ_HALF, 4'h8};
            8'hf4: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_XOR, `LBD_SZ_WORD, 4'h8};
            8'hb3: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_OR,  `LBD_SZ_BYTE, 4'h0};
            8'hb2: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_OR,  `LBD_SZ_HALF, 4'h0};
            8'hb0: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_OR,  `LBD_SZ_WORD, 4'h0};
            8'hf3: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_OR,  `LBD_SZ_BYTE, 4'h8};
            8'hf2: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_OR,  `LBD_SZ_HALF, 4'h8};
            8'hf0: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_OR,  `LBD_SZ_WORD, 4'h8};
            8'hd3: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_SHL, `LBD_SZ_BYTE, 4'h8};
            8'hd2: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_SHL, `LBD_SZ_HALF, 4'h8};
            8'hd0: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_SHL, `LBD_SZ_WORD, 4'h8};
            8'hd4: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_SHR, `LBD_SZ_WORD, 4'h8};
            8'hd8: lbd_decode = {1'b1, `LBD_GRP_LOGIC, `LBD_LOP_ROT, `LBD_SZ_WORD, 4'h8};
            8'h7b: lbd_decode = {1'b1, `LBD_GRP_BRA,  3'h0, 2'h0, 4'h2};
            8'h7a: lbd_decode = {1'b1, `LBD_GRP_BRA,  3'h0, 2'h0, 4'h7};
            8'h24: lbd_decode = {1'b1, `LBD_GRP_JUMP, 3'h0, `LBD_SZ_WORD, 4'h0};
            // shared encodings map to a single condition code
            8'h53: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_CC, 2'h0, 4'h2};
            8'h52: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_CC, 2'h0, 4'h7};
            8'h5b: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_CS, 2'h0, 4'h2};
            8'h5a: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_CS, 2'h0, 4'h7};
            8'h63: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_VC, 2'h0, 4'h2};
            8'h62: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_VC, 2'h0, 4'h7};
            8'h6b: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_VS, 2'h0, 4'h2};
            8'h6a: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_VS, 2'h0, 4'h7};
            8'h7f,
            8'h6f: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_EQ, 2'h0, 4'h2};
            8'h7e,
            8'h6e: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_EQ, 2'h0, 4'h7};
            8'h77,
            8'h67: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_NE, 2'h0, 4'h2};
            8'h76,
            8'h66: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_NE, 2'h0, 4'h7};
            8'h4b: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_LT, 2'h0, 4'h2};
            8'h4a: lbd_decode = {1'b1, `LBD_GRP_COND, `LBD_CND_LT, 2'h0, 4'h7};
            8'h37: lbd_decode = {1'b1, `LBD_GRP_CALL, 3'h0, 2'h0, 4'h2};
            8'h36: lbd_decode = {1'b1, `LBD_GRP_CALL, 3'h0, 2'h0, 4'h7};
            8'h78: lbd_decode = {1'b1, `LBD_GRP_RET,  3'h0, 2'h0, 4'h1};
            default: lbd_decode = 13'h0000;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// condition test
// ----------------------------------------------------------------
function lbd_cond_true;
    input [2:0] cnd;
    input [3:0] fl;
    begin
        case (cnd)
            `LBD_CND_CC: lbd_cond_true = ~fl[`LBD_FLAG_C];
            `LBD_CND_CS: lbd_cond_true = fl[`LBD_FLAG_C];
            `LBD_CND_VC: lbd_cond_true = ~fl[`LBD_FLAG_V];
            `LBD_CND_VS: lbd_cond_true = fl[`LBD_FLAG_V];
            `LBD_CND_EQ: lbd_cond_true = fl[`LBD_FLAG_Z];
            `LBD_CND_NE: lbd_cond_true = ~fl[`LBD_FLAG_Z];
            `LBD_CND_LT: lbd_cond_true = fl[`LBD_FLAG_N] ^ fl[`LBD_FLAG_V];
            default:     lbd_cond_true = 1'b0;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// sequential successor
// ----------------------------------------------------------------
// variable-length forms carry length zero, so pc stays put for them
function [31:0] lbd_next_pc;
    input [31:0] base;
    input [1:0]  len;
    begin
        lbd_next_pc = base + {30'h0, len};
    end
endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
localparam ST_IDLE = 1'b0;
localparam ST_RUN  = 1'b1;

reg         state_ff;
reg  [3:0]  cnt_ff;
reg  [7:0]  opcode_ff;
reg  [12:0] dec_ff;
reg  [3:0]  flags_ff;
reg  [31:0] pc_ff;
reg  [31:0] operand_ff;
reg  [31:0] saved_pc_ff;
reg  [31:0] target_ff;
reg         load_ff;
reg         done_ff;
reg         taken_ff;
reg         ill_ff;
reg  [31:0] rdata_ff;

reg         nxt_state;
reg  [3:0]  nxt_cnt;
reg         nxt_load;
reg         nxt_taken;
reg  [31:0] nxt_target;
reg  [31:0] nxt_rdata;

wire [12:0] cmd_dec   = lbd_decode(wdata[7:0]);
wire        start     = wr && (addr == `LBD_REG_CMD) && (state_ff == ST_IDLE);
wire [2:0]  cmd_grp   = cmd_dec[11:9];
wire [2:0]  cmd_cnd   = cmd_dec[8:6];
wire        cmd_long  = cmd_dec[2];
wire [31:0] disp      = cmd_long ? {{16{operand_ff[15]}}, operand_ff[15:0]}
                                 : {{24{operand_ff[7]}}, operand_ff[7:0]};
wire [31:0] seq_pc    = lbd_next_pc(pc_ff, cmd_dec[1:0]);
wire        cnd_hold  = lbd_cond_true(cmd_cnd, flags_ff);
wire        finish    = (state_ff == ST_RUN) && (cnt_ff == 4'h0);

assign busy = (state_ff == ST_RUN);
assign pc   = pc_ff;

// ----------------------------------------------------------------
// issue: pick target and completion time on command write
// ----------------------------------------------------------------
always @* begin
    nxt_load   = 1'b0;
    nxt_taken  = 1'b0;
    nxt_target = pc_ff;
    nxt_cnt    = `LBD_CYC_LOGIC - 4'd1;
    case (cmd_grp)
        `LBD_GRP_BRA: begin
            nxt_load   = 1'b1;
            nxt_taken  = 1'b1;
            nxt_target = pc_ff + disp;
            nxt_cnt    = `LBD_CYC_BRANCH - 4'd1;
        end
        `LBD_GRP_JUMP: begin
            nxt_load   = 1'b1;
            nxt_taken  = 1'b1;
            nxt_target = operand_ff;
            nxt_cnt    = `LBD_CYC_JUMP - 4'd1;
        end
        `LBD_GRP_COND: begin
            nxt_load   = 1'b1;
            nxt_taken  = cnd_hold;
            nxt_target = cnd_hold ? pc_ff + disp : seq_pc;
            nxt_cnt    = cnd_hold ? `LBD_CYC_TAKEN - 4'd1
                                  : `LBD_CYC_NOT_TAKEN - 4'd1;
        end
        `LBD_GRP_CALL: begin
            nxt_load   = 1'b1;
            nxt_taken  = 1'b1;
            nxt_target = pc_ff + disp;
            nxt_cnt    = `LBD_CYC_CALL - 4'd1;
        end
        `LBD_GRP_RET: begin
            nxt_load   = 1'b1;
            nxt_taken  = 1'b1;
            nxt_target = saved_pc_ff;
            nxt_cnt    = `LBD_CYC_RETURN - 4'd1;
        end
        default: begin
            nxt_load   = 1'b0;
        end
    endcase
end

always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_IDLE: begin
            if (start && cmd_dec[12]) begin
                nxt_state = ST_RUN;
            end
        end
        ST_RUN: begin
            if (cnt_ff == 4'h0) begin
                nxt_state = ST_IDLE;
            end
        end
        default: nxt_state = ST_IDLE;
    endcase
end

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_ff <= ST_IDLE;
        cnt_ff   <= 4'h0;
    end else begin
        state_ff <= nxt_state;
        if (start) begin
            cnt_ff <= nxt_cnt;
        end else if (state_ff == ST_RUN) begin
            cnt_ff <= cnt_ff - 4'd1;
        end
    end
end

// ----------------------------------------------------------------
// issue capture
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        opcode_ff <= 8'h00;
        dec_ff    <= 13'h0000;
        target_ff <= 32'h0000_0000;
        load_ff   <= 1'b0;
    end else if (start) begin
        opcode_ff <= wdata[7:0];
        dec_ff    <= cmd_dec;
        target_ff <= nxt_target;
        load_ff   <= nxt_load;
    end
end

// ----------------------------------------------------------------
// status
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        done_ff  <= 1'b0;
        taken_ff <= 1'b0;
        ill_ff   <= 1'b0;
    end else if (start) begin
        done_ff  <= 1'b0;
        // fixed at issue: a taken branch may land on pc+len anyway
        taken_ff <= nxt_taken;
        ill_ff   <= ~cmd_dec[12];
    end else if (finish) begin
        done_ff  <= 1'b1;
    end
end

// ----------------------------------------------------------------
// program counter and return address
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pc_ff <= `LBD_PC_RST;
    end else if (finish) begin
        if (load_ff) begin
            pc_ff <= target_ff;
        end
    end else if (wr && addr == `LBD_REG_PC && state_ff == ST_IDLE) begin
        pc_ff <= wdata;
    end
end

// one return address only: a nested call overwrites it
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        saved_pc_ff <= 32'h0000_0000;
    end else if (start && cmd_dec[12] && cmd_grp == `LBD_GRP_CALL) begin
        saved_pc_ff <= seq_pc;
    end
end

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
// flags are only written by software; no transfer touches them
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        flags_ff   <= `LBD_FLAGS_RST;
        operand_ff <= 32'h0000_0000;
    end else if (wr && state_ff == ST_IDLE) begin
        if (addr == `LBD_REG_FLAGS) begin
            flags_ff <= wdata[3:0];
        end
        if (addr == `LBD_REG_OPERAND) begin
            operand_ff <= wdata;
        end
    end
end

// ----------------------------------------------------------------
// read port
// ----------------------------------------------------------------
// zero outside the read slot so a late sampler sees no stale word
always @* begin
    nxt_rdata = 32'h0000_0000;
    if (rd) begin
        case (addr)
            `LBD_REG_CMD:      nxt_rdata = {24'h0, opcode_ff};
            `LBD_REG_FLAGS:    nxt_rdata = {28'h0, flags_ff};
            `LBD_REG_PC:       nxt_rdata = pc_ff;
            `LBD_REG_OPERAND:  nxt_rdata = operand_ff;
            `LBD_REG_STATUS:   nxt_rdata = {28'h0, ill_ff, taken_ff & done_ff, done_ff,
                                            busy};
            `LBD_REG_DECODE:   nxt_rdata = {19'h0, dec_ff};
            `LBD_REG_SAVED_PC: nxt_rdata = saved_pc_ff;
            default:           nxt_rdata = 32'h0000_0000;
        endcase
    end
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rdata_ff <= 32'h0000_0000;
    end else begin
        rdata_ff <= nxt_rdata;
    end
end

assign rdata = rdata_ff;

endmodule

// [tb/lbd_checker.sv]
`timescale 1ns/1ps
`include "lbd_consts.vh"
module lbd_checker (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        busy,
    input wire logic [31:0] pc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // --------------------------------
    // command launch
    // --------------------------------
    wire       cmd_go = wr && addr == `LBD_REG_CMD && !busy;
    wire [7:0] opc    = wdata[7:0];

    sequence s_run5;  busy [*5] ##1 !busy; endsequence
    sequence s_cond;  busy [*5] ##1 (!busy or (busy [*2] ##1 !busy)); endsequence
    sequence s_ret;   busy [*8] ##1 busy [*5] ##1 !busy; endsequence

    property p_logic;
        cmd_go && opc inside {8'hbb, 8'hba, 8'hb8, 8'hfb, 8'hfa, 8'hf8, 8'hb7, 8'hb6,
            8'hb4, 8'hf7, 8'hf6, 8'hf4, 8'hb3, 8'hb2, 8'hb0, 8'hf3, 8'hf2, 8'hf0,
            8'hd3, 8'hd2, 8'hd0, 8'hd4, 8'hd8} |=> busy ##1 !busy;
    endproperty
    a_logic: assert property (p_logic) else $error("logic op busy length wrong");
    property p_branch;
        cmd_go && (opc == 8'h7b || opc == 8'h7a) |=> s_run5;
    endproperty
    a_branch: assert property (p_branch) else $error("branch busy length wrong");
    property p_jump;
        cmd_go && opc == 8'h24 |=> busy [*7] ##1 !busy;
    endproperty
    a_jump: assert property (p_jump) else $error("jump busy length wrong");
    property p_cond;
        cmd_go && opc inside {8'h53, 8'h52, 8'h5b, 8'h5a, 8'h63, 8'h62, 8'h6b, 8'h6a,
            8'h7f, 8'h6f, 8'h7e, 8'h6e, 8'h77, 8'h67, 8'h76, 8'h66, 8'h4b, 8'h4a}
            |=> s_cond;
    endproperty
    a_cond: assert property (p_cond) else $error("conditional busy length wrong");
    property p_ret;
        cmd_go && opc == 8'h78 |=> s_ret;
    endproperty
    a_ret: assert property (p_ret) else $error("return busy length wrong");
    property p_pc_hold;
        busy ##1 busy |-> $stable(pc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved mid execution");
    property p_busy_cause;
        $rose(busy) |-> $past(cmd_go);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
    property p_busy_bound;
        $rose(busy) |-> ##[1:13] !busy;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
    property p_rd_idle;
        !rd |=> rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule

bind lbd_decoder lbd_checker i_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .pc(pc));

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "lbd_consts.vh"
module testbench;
    logic        clk;
    logic        rstn;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        busy;
    logic [31:0] pc;
    logic [31:0] v;
    logic [31:0] xp;
    logic [7:0]  op;
    logic [11:0] lt [0:22];
    logic [15:0] ct [0:18];
    integer      fail_count;
    integer      compares;
    integer      i;

    lbd_decoder i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .busy(busy), .pc(pc));

    always #10 clk = ~clk;

    // --------------------------------
    // bus and compare tasks
    // --------------------------------
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // counted on falling edges so the launching edge has settled
    task run_op(input logic [7:0] o, input logic [3:0] fl, input logic [31:0] xpc,
                input logic [3:0] xcyc);
        logic [31:0] n;
        wr_reg(`LBD_REG_FLAGS, {28'h0, fl});
        wr_reg(`LBD_REG_PC, 32'h0000_1000);
        wr_reg(`LBD_REG_OPERAND, 32'h0000_0180);
        wr_reg(`LBD_REG_CMD, {24'h0, o});
        n = 32'h0;
        @(negedge clk);
        while (busy === 1'b1 && n < 32'd40) begin
            n = n + 32'h1;
            @(negedge clk);
        end
        check("busy cycles", n, {28'h0, xcyc});
        check("pc", pc, xpc);
        rd_reg(`LBD_REG_FLAGS, v);
        check("flags", {28'h0, v[3:0]}, {28'h0, fl});
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #(20 * 20000);
        fail_count = fail_count + 1;
        summarize;
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        fail_count = 0;
        compares = 0;
        lt = '{12'hbb0, 12'hba0, 12'hb80, 12'hfb0, 12'hfa0, 12'hf80, 12'hb71, 12'hb61,
               12'hb41, 12'hf71, 12'hf61, 12'hf41, 12'hb32, 12'hb22, 12'hb02, 12'hf32,
               12'hf22, 12'hf02, 12'hd33, 12'hd23, 12'hd03, 12'hd44, 12'hd85};
        // op, taken, flags {n,z,v,c}; short forms odd, long forms even
        ct = '{16'h5310, 16'h5201, 16'h5b11, 16'h5a00, 16'h6310, 16'h6202, 16'h6b12,
               16'h6a00, 16'h7f14, 16'h6f00, 16'h7e14, 16'h6e14, 16'h7710, 16'h6704,
               16'h7610, 16'h6604, 16'h4b18, 16'h4a0a, 16'h4b12};
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check("pc after reset", pc, 32'h0);
        check("busy after reset", {31'h0, busy}, 32'h0);
        for (i = 0; i < 23; i = i + 1) begin
            op = lt[i][11:4];
            run_op(op, 4'h5, 32'h1000, `LBD_CYC_LOGIC);
            // size from the low opcode bits, three-address from the top two
            xp = {22'h0, 1'b1, `LBD_GRP_LOGIC, lt[i][2:0],
                  (op[1:0] == 2'b11) ? `LBD_SZ_BYTE :
                  (op[1:0] == 2'b10) ? `LBD_SZ_HALF : `LBD_SZ_WORD,
                  op[7:6] == 2'b11};
            rd_reg(`LBD_REG_DECODE, v);
            check("decode", {22'h0, v[12:3]}, xp);
        end
        run_op(8'h7b, 4'hf, 32'h0f80, `LBD_CYC_BRANCH);
        run_op(8'h7a, 4'h0, 32'h1180, `LBD_CYC_BRANCH);
        run_op(8'h24, 4'h3, 32'h0180, `LBD_CYC_JUMP);
        for (i = 0; i < 19; i = i + 1) begin
            op = ct[i][15:8];
            xp = ct[i][4] ? (op[0] ? 32'h0f80 : 32'h1180) : (op[0] ? 32'h1002 : 32'h1003);
            run_op(op, ct[i][3:0], xp, ct[i][4] ? `LBD_CYC_TAKEN : `LBD_CYC_NOT_TAKEN);
            rd_reg(`LBD_REG_STATUS, v);
            check("status", {28'h0, v[3:0]}, {28'h0, 1'b0, ct[i][4], 2'b10});
        end
        run_op(8'h37, 4'h0, 32'h0f80, `LBD_CYC_CALL);
        rd_reg(`LBD_REG_SAVED_PC, v);
        check("saved pc", v, 32'h1002);
        run_op(8'h78, 4'h0, 32'h1002, `LBD_CYC_RETURN);
        rd_reg(8'hfc, v);
        check("unmapped read", v, 32'h0);
        wr_reg(`LBD_REG_CMD, {24'h0, 8'h3f});
        rd_reg(`LBD_REG_STATUS, v);
        check("illegal status", v, 32'h8);
        // second command lands mid branch and must be dropped
        wr_reg(`LBD_REG_PC, 32'h0000_1000);
        wr_reg(`LBD_REG_CMD, {24'h0, 8'h7b});
        wr_reg(`LBD_REG_CMD, {24'h0, 8'h24});
        repeat (8) @(posedge clk);
        @(negedge clk);
        check("pc after refused command", pc, 32'h0f80);
        rd_reg(`LBD_REG_CMD, v);
        check("opcode after refused command", v, 32'h7b);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check("pc after second reset", pc, 32'h0);
        rd_reg(`LBD_REG_STATUS, v);
        check("status after second reset", v, 32'h0);
        summarize;
    end
endmodule
